// File: dv/sbl_mem_model.sv
// Purpose: far-side static device that can stretch accesses with its wait pin
// Assumes: selected whenever any chip select is low
// Notes: slow mode holds wait for four cycles after select

`timescale 1ns/100ps

module sbl_mem_model (
    // clock and pins
    input wire logic clk_sys,
    input wire logic [3:0] chipSelN,
    // behaviour
    input wire logic slowMode,
    // wait answer
    output logic extWaitN
);
    // ====
    // select age
    logic [2:0] holdCnt_r = 3'h0;

    always_ff @(posedge clk_sys) begin
        if (&chipSelN) begin
            holdCnt_r <= 3'h0;
        end else if (holdCnt_r != 3'h7) begin
            holdCnt_r <= holdCnt_r + 3'h1;
        end
    end

    // wait pin is active low, driven high when released
    assign extWaitN = ~(slowMode && !(&chipSelN) && (holdCnt_r < 3'h4));

endmodule : sbl_mem_model

// File: dv/tb.sv
// Purpose: self-checking bench of the byte lane mapper
// Assumes: pins follow inputs after one register stage
// Notes: expected pins worked out by hand per width and access type

`timescale 1ns/100ps

module tb;
    import sbl_pkg::*;
    // ====
    // signals
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    sbl_width_type busWidth [NUM_CS];
    sbl_bat_type byteAccessType [NUM_CS];
    logic accValid = 1'b0;
    sbl_acc_type acc = '0;
    sbl_phase_type phase = '0;
    logic slowMode = 1'b0;
    logic extWaitN;
    logic [NUM_CS-1:0] chipSelN_r;
    logic readStrobeN_r;
    logic writePinN_r;
    logic [LANES-1:0] lanePinN_r;
    logic [ADDR_W-1:ADDR_LO] extAddr_r;
    logic waitReq_r;
    int n_fail = 0;
    int compares = 0;

    always #12.5 clk_sys = ~clk_sys;

    sbl_lane_mapper u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .busWidth(busWidth),
        .byteAccessType(byteAccessType), .accValid(accValid), .acc(acc), .phase(phase),
        .extWaitN(extWaitN), .chipSelN_r(chipSelN_r), .readStrobeN_r(readStrobeN_r),
        .writePinN_r(writePinN_r), .lanePinN_r(lanePinN_r), .extAddr_r(extAddr_r), .waitReq_r(waitReq_r));
    sbl_mem_model u_mem (.clk_sys(clk_sys), .chipSelN(chipSelN_r), .slowMode(slowMode), .extWaitN(extWaitN));

    // ====
    // helpers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // one access held two cycles, then released; pins checked in both states
    task automatic run_acc(input logic [1:0] cs, input logic wr, input sbl_size_type sz, input logic [25:0] ad,
        input logic [3:0] expLane, input logic expWp, input logic [3:0] expIdle);
        logic [3:0] csExp;
        csExp = ~(4'h1 << cs);
        @(posedge clk_sys);
        acc <= '{cs: cs, write: wr, size: sz, addr: ad};
        accValid <= 1'b1;
        phase <= '{csOn: 1'b1, rdOn: ~wr, wrOn: wr};
        @(posedge clk_sys);
        #1;
        chk("chip select", csExp, chipSelN_r);
        chk("address", ad[25:2], extAddr_r);
        chk("read strobe", wr, readStrobeN_r);
        chk("write pin", expWp, writePinN_r);
        chk("lanes", expLane, lanePinN_r);
        @(posedge clk_sys);
        accValid <= 1'b0;
        phase <= '0;
        @(posedge clk_sys);
        #1;
        chk("idle select", 4'hf, chipSelN_r);
        chk("idle write pin", 1'b1, writePinN_r);
        chk("idle lanes", expIdle, lanePinN_r);
    endtask : run_acc

    // ====
    // scenarios
    task automatic t_reset();
        chk("reset lanes", 4'hf, lanePinN_r);
        chk("reset select", 4'hf, chipSelN_r);
        chk("reset wait", 1'b0, waitReq_r);
        $display("test reset done");
    endtask : t_reset

    task automatic t_w8();
        run_acc(2'h0, 1'b1, SBL_SZ_BYTE, 26'h3fffffe, 4'he, 1'b0, 4'he);
        run_acc(2'h0, 1'b0, SBL_SZ_BYTE, 26'h0000001, 4'hb, 1'b1, 4'hb);
        $display("test width8 done");
    endtask : t_w8

    task automatic t_bs16();
        run_acc(2'h2, 1'b1, SBL_SZ_BYTE, 26'h0000001, 4'h9, 1'b0, 4'h9);
        run_acc(2'h2, 1'b0, SBL_SZ_HALF, 26'h0000002, 4'hc, 1'b1, 4'hc);
        $display("test select16 done");
    endtask : t_bs16

    task automatic t_bw16();
        run_acc(2'h3, 1'b1, SBL_SZ_BYTE, 26'h0000001, 4'h9, 1'b1, 4'hb);
        run_acc(2'h3, 1'b1, SBL_SZ_HALF, 26'h0000000, 4'h9, 1'b0, 4'hb);
        $display("test write16 done");
    endtask : t_bw16

    task automatic t_bw32();
        run_acc(2'h1, 1'b1, SBL_SZ_BYTE, 26'h0000002, 4'hb, 1'b1, 4'hf);
        run_acc(2'h1, 1'b0, SBL_SZ_WORD, 26'h0000000, 4'hf, 1'b1, 4'hf);
        run_acc(2'h1, 1'b1, SBL_SZ_HALF, 26'h0000002, 4'h3, 1'b1, 4'hf);
        $display("test write32 done");
    endtask : t_bw32

    task automatic t_bs32();
        @(posedge clk_sys);
        busWidth[0] <= SBL_W32;
        run_acc(2'h0, 1'b1, SBL_SZ_WORD, 26'h0000000, 4'h0, 1'b0, 4'h0);
        run_acc(2'h0, 1'b0, SBL_SZ_BYTE, 26'h0000003, 4'h7, 1'b1, 4'h7);
        run_acc(2'h0, 1'b1, SBL_SZ_HALF, 26'h0000002, 4'h3, 1'b0, 4'h3);
        $display("test select32 done");
    endtask : t_bs32

    task automatic t_wait();
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys);
        slowMode <= 1'b1;
        acc <= '{cs: 2'h2, write: 1'b0, size: SBL_SZ_BYTE, addr: 26'h0};
        accValid <= 1'b1;
        phase <= '{csOn: 1'b1, rdOn: 1'b1, wrOn: 1'b0};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys);
            #1;
            if (waitReq_r === 1'b1) seen = 1'b1;
        end
        chk("wait seen", 1'b1, seen);
        @(posedge clk_sys);
        accValid <= 1'b0;
        phase <= '0;
        slowMode <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("wait dropped", 1'b0, waitReq_r);
        $display("test wait done");
    endtask : t_wait

    // ====
    // main sequence
    initial begin
        for (int i = 0; i < NUM_CS; i++) begin
            busWidth[i] = SBL_W16;
            byteAccessType[i] = SBL_BYTE_SEL;
        end
        busWidth[0] = SBL_W8;
        busWidth[1] = SBL_W32;
        byteAccessType[1] = SBL_BYTE_WR;
        byteAccessType[3] = SBL_BYTE_WR;
        // reset values are only idle while reset holds; after it the held access drives the lanes
        repeat (2) @(posedge clk_sys);
        #1;
        t_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_w8();
        t_bs16();
        t_bw16();
        t_bw32();
        t_bs32();
        t_wait();
        print_verdict();
    end

endmodule : tb

// File: hdl/sbl_lane_decode.sv
// Purpose: active byte lanes of one access from width, size and low address
// Assumes: accesses wider than the bus are split upstream
// Notes: purely combinational

`timescale 1ns/100ps

module sbl_lane_decode (
    // access description
    input wire sbl_pkg::sbl_width_type busWidth,
    input wire sbl_pkg::sbl_size_type accSize,
    input wire logic [1:0] addrLow,
    // result
    output logic [sbl_pkg::LANES-1:0] laneMask
);
    import sbl_pkg::*;

    logic [2:0] widthBytes;
    logic [2:0] sizeBytes;
    logic [2:0] loLane;
    logic [2:0] hiLane;

    // ==========================================================
    // lane window
    always_comb begin
        case (busWidth)
            SBL_W8: widthBytes = BYTES_1;
            SBL_W16: widthBytes = BYTES_2;
            default: widthBytes = BYTES_4;
        endcase
        case (accSize)
            SBL_SZ_BYTE: sizeBytes = BYTES_1;
            SBL_SZ_HALF: sizeBytes = BYTES_2;
            default: sizeBytes = BYTES_4;
        endcase
        // a transfer wider than the bus is one bus beat here
        if (sizeBytes > widthBytes) begin
            sizeBytes = widthBytes;
        end
        loLane = {1'b0, addrLow} & (widthBytes - BYTES_1) & ~(sizeBytes - BYTES_1);
        hiLane = 3'(loLane + sizeBytes - BYTES_1);
    end

    // R18 lane selection
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign laneMask[i] = (3'(i) < widthBytes) && (3'(i) >= loLane) && (3'(i) <= hiLane);
    end

endmodule : sbl_lane_decode

// File: hdl/sbl_lane_mapper.sv
// Purpose: pin mapping of a static memory controller per chip select
// Assumes: strobe timing phases come from the controller core on clk_sys
// Notes: config inputs must be stable while their chip select is in use
//
// Overview of operation
// R1 - strobes and selects active low, wait low
// R2 - 26 address bits, 64 MB per select
// R3 - small devices wrap, surplus bits ignored
// R4 - significant address bits depend on width
// R5 - width chosen per chip select
// R6 - byte write or byte select per select
// R7 - 16-bit byte write: two strobes, one read
// R8 - 32-bit byte write: four strobes, one read
// R9 - byte select: lane selects, read, write enable
// R10 - 16-bit byte select uses selects 0,1
// R11 - 32-bit byte select uses four selects
// R12 - A0 unused 16-bit, A0/A1 unused 32-bit
// R13 - unused strobes or selects stay idle
// R14 - lane0 pin select or A0; write pin
// R15 - lane2 pin select/strobe or A1
// R16 - byte selects follow address timing
// R17 - byte strobes follow write enable timing
// R18 - only addressed lanes are asserted

`timescale 1ns/100ps

module sbl_lane_mapper (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // per chip select configuration
    input wire sbl_pkg::sbl_width_type busWidth [sbl_pkg::NUM_CS],
    input wire sbl_pkg::sbl_bat_type byteAccessType [sbl_pkg::NUM_CS],
    // access and strobe phases from the core
    input wire logic accValid,
    input wire sbl_pkg::sbl_acc_type acc,
    input wire sbl_pkg::sbl_phase_type phase,
    // external pins
    input wire logic extWaitN,
    output logic [sbl_pkg::NUM_CS-1:0] chipSelN_r,
    output logic readStrobeN_r,
    output logic writePinN_r,
    output logic [sbl_pkg::LANES-1:0] lanePinN_r,
    output logic [sbl_pkg::ADDR_W-1:sbl_pkg::ADDR_LO] extAddr_r,
    // to the core
    output logic waitReq_r
);
    import sbl_pkg::*;

    sbl_acc_type held_r;
    sbl_acc_type held_nxt;
    sbl_acc_type cur;
    sbl_width_type curWidth;
    sbl_bat_type curBat;
    logic [LANES-1:0] laneMask;
    logic [NUM_CS-1:0] chipSelN_nxt;
    logic readStrobeN_nxt;
    logic writePinN_nxt;
    logic [LANES-1:0] lanePinN_nxt;
    logic [ADDR_W-1:ADDR_LO] extAddr_nxt;
    logic wrAct;
    logic byteWrMode;
    logic waitSync1_r;
    logic waitSync2_r;
    logic waitReq_nxt;

    // ==========================================================
    // current access: address and byte selects hold between accesses
    assign cur = accValid ? acc : held_r;
    // R5 width per select
    assign curWidth = busWidth[cur.cs];
    assign curBat = byteAccessType[cur.cs];

    sbl_lane_decode u_decode (
        .busWidth(curWidth),
        .accSize(cur.size),
        .addrLow(cur.addr[1:0]),
        .laneMask(laneMask)
    );

    // ==========================================================
    // pin mapping
    always_comb begin
        held_nxt = cur;
        // R6 byte write only exists above 8 bits
        byteWrMode = (curBat == SBL_BYTE_WR) && (curWidth != SBL_W8);
        wrAct = accValid && phase.wrOn && acc.write;
        // R1 active low selects
        chipSelN_nxt = CS_IDLE;
        if (accValid && phase.csOn) begin
            chipSelN_nxt[acc.cs] = 1'b0;
        end
        // R7 one shared read strobe
        readStrobeN_nxt = !(accValid && phase.rdOn && !acc.write);
        // R2 full upper address, R3 wrap left to the device
        extAddr_nxt = cur.addr[ADDR_W-1:ADDR_LO];
        lanePinN_nxt = LANE_IDLE;
        writePinN_nxt = PIN_IDLE;
        if (byteWrMode) begin
            // R8 one strobe per lane
            // R17 byte strobes share the write enable phase
            for (int i = 0; i < LANES; i++) begin
                lanePinN_nxt[i] = !(wrAct && laneMask[i]);
            end
            // R14 write pin is strobe 0 here
            writePinN_nxt = lanePinN_nxt[0];
            // R13 no byte select function on lane0
            lanePinN_nxt[0] = PIN_IDLE;
        end else begin
            // R9 byte selects with one write enable
            writePinN_nxt = !wrAct;
            // R10 selects from lane 0 up
            // R16 selects track the held address
            lanePinN_nxt = ~laneMask;
        end
        // R4 low address on shared pins by width
        case (curWidth)
            SBL_W8: begin
                // R14 lane0 carries A0
                lanePinN_nxt[0] = cur.addr[0];
                lanePinN_nxt[1] = PIN_IDLE;
                lanePinN_nxt[2] = cur.addr[1];
                lanePinN_nxt[3] = PIN_IDLE;
            end
            SBL_W16: begin
                // R12 A0 unused, R15 lane2 carries A1
                lanePinN_nxt[2] = cur.addr[1];
                lanePinN_nxt[3] = PIN_IDLE;
            end
            default: begin
                // R11 all four lanes keep their lane function
                lanePinN_nxt = lanePinN_nxt;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            held_r <= '0;
            chipSelN_r <= CS_IDLE;
            readStrobeN_r <= PIN_IDLE;
            writePinN_r <= PIN_IDLE;
            lanePinN_r <= LANE_IDLE;
            extAddr_r <= ADDR_RST[ADDR_W-1:ADDR_LO];
        end else begin
            held_r <= held_nxt;
            chipSelN_r <= chipSelN_nxt;
            readStrobeN_r <= readStrobeN_nxt;
            writePinN_r <= writePinN_nxt;
            lanePinN_r <= lanePinN_nxt;
            extAddr_r <= extAddr_nxt;
        end
    end

    // ==========================================================
    // wait input: async pin, two flops before use
    always_comb begin
        // R1 wait asserted when low
        waitReq_nxt = !waitSync2_r;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            waitSync1_r <= PIN_IDLE;
            waitSync2_r <= PIN_IDLE;
            waitReq_r <= 1'b0;
        end else begin
            waitSync1_r <= extWaitN;
            waitSync2_r <= waitSync1_r;
            waitReq_r <= waitReq_nxt;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_wait_low;
        !extWaitN ##1 !extWaitN ##1 !extWaitN;
    endsequence

    property p_cs_one;
        accValid && phase.csOn |=> ($countones(~chipSelN_r) == 1) && !chipSelN_r[$past(acc.cs)];
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("selected chip select not low"); // R1

    property p_cs_idle;
        !(accValid && phase.csOn) |=> chipSelN_r == CS_IDLE;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("chip select low while idle"); // R1

    property p_read;
        accValid && phase.rdOn && !acc.write |=> !readStrobeN_r && writePinN_r;
    endproperty
    a_read: assert property (p_read) else $error("read strobe wrong"); // R7

    property p_a0_8bit;
        accValid && busWidth[acc.cs] == SBL_W8 |=> lanePinN_r[0] == $past(acc.addr[0]);
    endproperty
    a_a0_8bit: assert property (p_a0_8bit) else $error("lane0 not A0 on 8-bit bus"); // R14

    property p_a1_narrow;
        accValid && busWidth[acc.cs] != SBL_W32 |=> lanePinN_r[2] == $past(acc.addr[1]) && lanePinN_r[3];
    endproperty
    a_a1_narrow: assert property (p_a1_narrow) else $error("lane2 not A1 on narrow bus"); // R15

    property p_word_sel;
        accValid && busWidth[acc.cs] == SBL_W32 && byteAccessType[acc.cs] == SBL_BYTE_SEL
            && acc.size == SBL_SZ_WORD |=> lanePinN_r == 4'h0;
    endproperty
    a_word_sel: assert property (p_word_sel) else $error("word access misses a lane"); // R11

    property p_bwr_idle;
        accValid && busWidth[acc.cs] == SBL_W32 && byteAccessType[acc.cs] == SBL_BYTE_WR
            && !phase.wrOn |=> lanePinN_r == LANE_ALL && writePinN_r;
    endproperty
    a_bwr_idle: assert property (p_bwr_idle) else $error("byte strobe outside write phase"); // R13

    property p_byte_wr;
        accValid && acc.write && phase.wrOn && busWidth[acc.cs] == SBL_W32
            && byteAccessType[acc.cs] == SBL_BYTE_WR && acc.size == SBL_SZ_BYTE
            |=> $countones(~{lanePinN_r[3:1], writePinN_r}) == 1;
    endproperty
    a_byte_wr: assert property (p_byte_wr) else $error("byte write drives other than one strobe"); // R18

    property p_hold;
        !accValid ##1 !accValid |-> $stable(extAddr_r) && $stable(lanePinN_r[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("address side pins moved while idle"); // R16

    property p_wait;
        s_wait_low |=> waitReq_r;
    endproperty
    a_wait: assert property (p_wait) else $error("wait not seen after three low cycles"); // R1

endmodule : sbl_lane_mapper

// File: hdl/sbl_pkg.sv
// Purpose: shared types and constants of the static memory byte lane mapper
// Assumes: four chip selects, 26-bit external address
// Notes: pins are active low, so idle values are all ones

package sbl_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CS = 4;
    localparam int CS_W = 2;
    localparam int ADDR_W = 26;
    localparam int ADDR_LO = 2;
    localparam int LANES = 4;

    // ==========================================================
    // idle and reset values of the pins
    localparam logic [NUM_CS-1:0] CS_IDLE = 4'hf;
    localparam logic [LANES-1:0] LANE_IDLE = 4'hf;
    localparam logic [LANES-1:0] LANE_ALL = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
    localparam logic PIN_IDLE = 1'b1;

    // ==========================================================
    // lane decode constants
    localparam logic [2:0] BYTES_1 = 3'h1;
    localparam logic [2:0] BYTES_2 = 3'h2;
    localparam logic [2:0] BYTES_4 = 3'h4;

    // ==========================================================
    // modes and carriers
    typedef enum logic [1:0] {SBL_W8, SBL_W16, SBL_W32} sbl_width_type;
    typedef enum logic {SBL_BYTE_SEL, SBL_BYTE_WR} sbl_bat_type;
    typedef enum logic [1:0] {SBL_SZ_BYTE, SBL_SZ_HALF, SBL_SZ_WORD} sbl_size_type;

    typedef struct packed {
        logic [CS_W-1:0] cs;
        logic write;
        sbl_size_type size;
        logic [ADDR_W-1:0] addr;
    } sbl_acc_type;

    typedef struct packed {
        logic csOn;
        logic rdOn;
        logic wrOn;
    } sbl_phase_type;

endpackage : sbl_pkg
